// File: dai_ecc_check.sv
`timescale 1ns/100ps
// one-bit correct, two-bit detect check of a code word
module dai_ecc_check
    import dai_pkg::*;
(
    input logic ref_clk,
    input logic sys_rst,
    input logic word_valid,
    input logic [dai_pkg::ECC_CW-1:0] code_word,
    output logic [dai_pkg::ECC_DW-1:0] fixed_data,
    output logic one_bit_detect,
    output logic two_bit_detect,
    output logic result_valid
);
    // hamming syndrome over positions 1..12
    function automatic logic [3:0] syndrome(input logic [ECC_CW-1:0] w);
        logic [3:0] s;
        s = 4'h0;
        for (int i = 1; i < ECC_CW; i++) begin
            if (w[i]) begin
                s = s ^ i[3:0];
            end
        end
        return s;
    endfunction : syndrome

    logic [3:0] syn; // error position, zero when clean
    logic par; // overall parity, one on odd error count
    logic [ECC_CW-1:0] mended; // word with one flipped bit restored
    logic [ECC_DW-1:0] data_bits; // data picked from non-power positions

    // decode and correct in one combinational step
    always_comb begin
        int k;
        k = 0;
        syn = syndrome(code_word);
        par = ^code_word;
        mended = code_word;
        if (par) begin
            mended[syn] = ~code_word[syn];
        end
        data_bits = '0;
        for (int i = 3; i < ECC_CW; i++) begin
            if ((i & (i - 1)) != 0) begin
                data_bits[k] = mended[i];
                k = k + 1;
            end
        end
    end

    // register the corrected value and the two verdicts
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fixed_data <= '0;
            one_bit_detect <= 1'b0;
            two_bit_detect <= 1'b0;
            result_valid <= 1'b0;
        end else begin
            result_valid <= word_valid;
            if (word_valid) begin
                fixed_data <= data_bits;
                one_bit_detect <= par;
                two_bit_detect <= !par && (syn != 4'h0);
            end
        end
    end
endmodule : dai_ecc_check

// File: dai_host_model.sv
`timescale 1ns/100ps
// host side of the alert line and of the serial transfers
module dai_host_model (
    input logic ref_clk,
    input logic pin_oe,
    output logic pin_level,
    output logic xfer_fail,
    output logic xfer_ok
);
    // pull-up on the open-drain line: low only while the device pulls
    assign pin_level = ~pin_oe;
    initial begin
        xfer_fail = 1'b0;
        xfer_ok = 1'b0;
    end
    // one transfer outcome, one cycle wide
    task automatic transfer(input logic bad);
        @(negedge ref_clk);
        xfer_fail = bad;
        xfer_ok = ~bad;
        @(negedge ref_clk);
        xfer_fail = 1'b0;
        xfer_ok = 1'b0;
    endtask : transfer
endmodule : dai_host_model

// File: dai_pkg.sv
package dai_pkg;
    // clock rate in MHz
    localparam int CLK_MHZ = 25;
    // window of the time base counter, in ns
    localparam int OSC_GATE_NS = 100000;
    localparam int OSC_GATE_CYC = (OSC_GATE_NS * CLK_MHZ) / 1000;
    // quiet time before oscillator counts as stopped, ns
    localparam int OSC_STUCK_NS = 10000;
    localparam int OSC_STUCK_CYC = (OSC_STUCK_NS * CLK_MHZ) / 1000;
    // width of the oscillator measurement
    localparam int OSC_W = 16;
    // ecc geometry: 8 data bits, 13-bit code word
    localparam int ECC_DW = 8;
    localparam int ECC_CW = 13;
    // flag positions in the flag vector
    localparam int FLAG_N = 13;
    localparam int F_OVER = 0;
    localparam int F_UNDER = 1;
    localparam int F_ACCESS = 2;
    localparam int F_PROTO = 3;
    localparam int F_SH_TWO = 4;
    localparam int F_SH_ONE = 5;
    localparam int F_NV_TWO = 6;
    localparam int F_NV_ONE = 7;
    localparam int F_OSC_RANGE = 8;
    localparam int F_OSC_STUCK = 9;
    localparam int F_SUPPLY_PIN = 10;
    localparam int F_LOW_AMP = 11;
    localparam int F_IBUS = 12;
    // serial interface modes
    typedef enum logic [1:0] {
        DAI_IF_SPI = 2'h0,
        DAI_IF_SPI_IRQ = 2'h1,
        DAI_IF_I2C_IRQ = 2'h2,
        DAI_IF_I2C_SEL = 2'h3
    } dai_if_mode_t;
    // diagnostic signalling on the four track pins
    typedef enum logic [1:0] {
        DAI_HS_OFF = 2'h0,
        DAI_HS_LOW = 2'h1,
        DAI_HS_HIGH = 2'h2,
        DAI_HS_RSVD = 2'h3
    } dai_hs_mode_t;
    // reset values of the captured interface settings
    localparam logic [1:0] IF_MODE_RST = 2'h3;
    localparam logic [6:0] I2C_ADDR_RST = 7'h00;
endpackage : dai_pkg

// File: dai_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// - each fault sets its own readable flag; analog supply low and both pin over-voltages share F_SUPPLY_PIN
// - per-flag enable routes flag to interrupt pin
// - enabled event also forces track outputs diagnostic
// - track diagnostic: forced low, high, or off
// - static flags cleared only by power-on reset
// - temporary flags drop when cause goes away
// - continuous checks always, start-up checks once
// - over-voltage flag with hysteresis per mode
// - under-voltage flag with hysteresis per mode
// - failed serial transfer sets protocol flag
// - shadow two-bit error sets static flag
// - shadow one-bit error flagged and corrected
// - start-up memory two-bit error static flag
// - start-up memory one-bit error flagged, corrected
// - time base measures oscillator against limits
// - range flag while frequency outside limits
// - stuck flag while oscillator stopped
// - combined flag: analog supply or pin over-voltage
// - low amplitude flag in incremental mode
// - write lock makes access read-only
// - four serial interface modes selectable
// - spi polarity, phase and bit order selectable
// - i2c address programmable, select or interrupt
// - i2c interrupt mode drives alert pin
module dai_top
    import dai_pkg::*;
#(
    parameter int GATE_CYC = dai_pkg::OSC_GATE_CYC,
    parameter int STUCK_CYC = dai_pkg::OSC_STUCK_CYC
)(
    input logic ref_clk,
    input logic sys_rst,
    // supply comparators, index 0 for 3.3 V mode, 1 for 5 V mode
    input logic supply_5v_mode,
    input logic [1:0] over_trip,
    input logic [1:0] over_release,
    input logic [1:0] under_trip,
    input logic [1:0] under_release,
    // plain fault sources
    input logic data_access_err,
    input logic internal_bus_err,
    input logic xfer_fail,
    input logic xfer_ok,
    input logic internal_analog_supply_low,
    input logic alert_pin_over,
    input logic line_pin_over,
    input logic incremental_mode,
    input logic amplitude_low,
    // shadow bank and start-up memory words
    input logic shadow_valid,
    input logic [dai_pkg::ECC_CW-1:0] shadow_word,
    input logic startup_active,
    input logic nvm_valid,
    input logic [dai_pkg::ECC_CW-1:0] nvm_word,
    // transmitter oscillator, one pulse per divided edge
    input logic osc_tick,
    input logic [dai_pkg::OSC_W-1:0] osc_upper,
    input logic [dai_pkg::OSC_W-1:0] osc_lower,
    // enables and signalling choice
    input logic [dai_pkg::FLAG_N-1:0] irq_enable,
    input logic [1:0] hs_mode,
    input logic [3:0] track_drive,
    // write lock
    input logic lock_set,
    input logic write_req,
    // serial settings, taken over when start-up ends
    input logic [1:0] cfg_if_mode,
    input logic cfg_cpol,
    input logic cfg_cpha,
    input logic cfg_lsb_first,
    input logic [6:0] cfg_i2c_addr,
    // alert pin, open-drain
    input logic select_or_alert_pin_in,
    output logic select_or_alert_pin_out,
    output logic select_or_alert_pin_oe,
    // outputs
    output logic [dai_pkg::FLAG_N-1:0] flags,
    output logic alert_active,
    output logic first_track_out_p,
    output logic first_track_out_n,
    output logic second_track_out_p,
    output logic second_track_out_n,
    output logic [dai_pkg::ECC_DW-1:0] shadow_data,
    output logic [dai_pkg::ECC_DW-1:0] nvm_data,
    output logic [dai_pkg::OSC_W-1:0] osc_measure,
    output logic write_locked,
    output logic write_accept,
    output logic [1:0] if_mode,
    output logic spi_cpol,
    output logic spi_cpha,
    output logic spi_lsb_first,
    output logic [6:0] i2c_addr
);
    import dai_pkg::*;

    // hysteresis flag: set on trip, held until release level
    function automatic logic hyst(input logic cur, input logic trip,
                                  input logic rel);
        return trip | (cur & ~rel);
    endfunction : hyst

    logic sh_one; // shadow one-bit verdict
    logic sh_two; // shadow two-bit verdict
    logic sh_done; // shadow verdict strobe
    logic nv_one; // memory one-bit verdict
    logic nv_two; // memory two-bit verdict
    logic nv_done; // memory verdict strobe
    logic nv_chk; // memory word read during start-up
    logic boot_seen; // start-up phase has been entered
    logic boot_over; // start-up phase has ended
    logic [31:0] gate_cnt; // time base window counter
    logic [OSC_W-1:0] tick_cnt; // oscillator ticks in this window
    logic [31:0] quiet_cnt; // cycles since last oscillator tick
    logic measured; // a full window has been measured
    logic any_irq; // some enabled flag is asserted
    logic irq_mode; // alert pin is an interrupt output

    // shadow bank: checked on every read
    dai_ecc_check u_shadow_ecc (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .word_valid(shadow_valid),
        .code_word(shadow_word),
        .fixed_data(shadow_data),
        .one_bit_detect(sh_one),
        .two_bit_detect(sh_two),
        .result_valid(sh_done)
    );

    // start-up memory: only words read during start-up are checked
    assign nv_chk = nvm_valid & startup_active & ~boot_over;

    dai_ecc_check u_nvm_ecc (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .word_valid(nv_chk),
        .code_word(nvm_word),
        .fixed_data(nvm_data),
        .one_bit_detect(nv_one),
        .two_bit_detect(nv_two),
        .result_valid(nv_done)
    );

    // start-up phase tracking, ends once and never restarts
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            boot_seen <= 1'b0;
            boot_over <= 1'b0;
        end else begin
            if (startup_active) begin
                boot_seen <= 1'b1;
            end
            if (boot_seen && !startup_active) begin
                boot_over <= 1'b1;
            end
        end
    end

    // supply flags, comparator pair chosen by supply mode
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags[F_OVER] <= 1'b0;
            flags[F_UNDER] <= 1'b0;
        end else begin
            flags[F_OVER] <= hyst(flags[F_OVER],
                over_trip[supply_5v_mode],
                over_release[supply_5v_mode]);
            flags[F_UNDER] <= hyst(flags[F_UNDER],
                under_trip[supply_5v_mode],
                under_release[supply_5v_mode]);
        end
    end

    // level-following temporary flags
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags[F_ACCESS] <= 1'b0;
            flags[F_IBUS] <= 1'b0;
            flags[F_SUPPLY_PIN] <= 1'b0;
            flags[F_LOW_AMP] <= 1'b0;
        end else begin
            flags[F_ACCESS] <= data_access_err;
            flags[F_IBUS] <= internal_bus_err;
            flags[F_SUPPLY_PIN] <= internal_analog_supply_low
                | alert_pin_over | line_pin_over;
            flags[F_LOW_AMP] <= incremental_mode & amplitude_low;
        end
    end

    // protocol flag: held from a failed transfer to a good one
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags[F_PROTO] <= 1'b0;
        end else if (xfer_fail) begin
            flags[F_PROTO] <= 1'b1;
        end else if (xfer_ok) begin
            flags[F_PROTO] <= 1'b0;
        end
    end

    // ecc flags: two-bit ones stick, one-bit ones follow the last word
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags[F_SH_TWO] <= 1'b0;
            flags[F_SH_ONE] <= 1'b0;
            flags[F_NV_TWO] <= 1'b0;
            flags[F_NV_ONE] <= 1'b0;
        end else begin
            if (sh_done) begin
                flags[F_SH_TWO] <= flags[F_SH_TWO] | sh_two;
                flags[F_SH_ONE] <= sh_one;
            end
            if (nv_done) begin
                flags[F_NV_TWO] <= flags[F_NV_TWO] | nv_two;
                flags[F_NV_ONE] <= nv_one;
            end
        end
    end

    // time base: count oscillator ticks over a fixed window
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gate_cnt <= '0;
            tick_cnt <= '0;
            osc_measure <= '0;
            measured <= 1'b0;
        end else if (gate_cnt == 32'(GATE_CYC - 1)) begin
            gate_cnt <= '0;
            tick_cnt <= '0;
            osc_measure <= tick_cnt + OSC_W'(osc_tick);
            measured <= 1'b1;
        end else begin
            gate_cnt <= gate_cnt + 32'h1;
            if (osc_tick && tick_cnt != '1) begin
                tick_cnt <= tick_cnt + 1'b1;
            end
        end
    end

    // range flag against the programmed limits
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags[F_OSC_RANGE] <= 1'b0;
        end else begin
            flags[F_OSC_RANGE] <= measured && ((osc_measure > osc_upper)
                || (osc_measure < osc_lower));
        end
    end

    // stuck flag: no tick for the quiet limit
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            quiet_cnt <= '0;
            flags[F_OSC_STUCK] <= 1'b0;
        end else if (osc_tick) begin
            quiet_cnt <= '0;
            flags[F_OSC_STUCK] <= 1'b0;
        end else if (quiet_cnt >= 32'(STUCK_CYC - 1)) begin
            flags[F_OSC_STUCK] <= 1'b1;
        end else begin
            quiet_cnt <= quiet_cnt + 32'h1;
        end
    end

    // enabled flags collapse to one event
    assign any_irq = |(flags & irq_enable);
    assign irq_mode = (if_mode == DAI_IF_I2C_IRQ)
        || (if_mode == DAI_IF_SPI_IRQ);

    // alert pin: pulled low in an interrupt mode while an enabled flag stands
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            alert_active <= 1'b0;
            select_or_alert_pin_out <= 1'b0;
            select_or_alert_pin_oe <= 1'b0;
        end else begin
            alert_active <= any_irq;
            select_or_alert_pin_oe <= irq_mode & any_irq;
        end
    end

    // track pins: normal drive, or forced in diagnostic state
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {second_track_out_n, second_track_out_p, first_track_out_n,
                first_track_out_p} <= 4'h0;
        end else if (any_irq && hs_mode == DAI_HS_LOW) begin
            {second_track_out_n, second_track_out_p, first_track_out_n,
                first_track_out_p} <= 4'h0;
        end else if (any_irq && hs_mode == DAI_HS_HIGH) begin
            {second_track_out_n, second_track_out_p, first_track_out_n,
                first_track_out_p} <= 4'hF;
        end else begin
            {second_track_out_n, second_track_out_p, first_track_out_n,
                first_track_out_p} <= track_drive;
        end
    end

    // write lock: sticky until power-on reset, gates every write
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            write_locked <= 1'b0;
            write_accept <= 1'b0;
        end else begin
            if (lock_set) begin
                write_locked <= 1'b1;
            end
            write_accept <= write_req & ~write_locked & ~lock_set;
        end
    end

    // serial settings take effect once, when start-up ends
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            if_mode <= IF_MODE_RST;
            spi_cpol <= 1'b0;
            spi_cpha <= 1'b0;
            spi_lsb_first <= 1'b0;
            i2c_addr <= I2C_ADDR_RST;
        end else if (boot_seen && !startup_active && !boot_over) begin
            if_mode <= cfg_if_mode;
            spi_cpol <= cfg_cpol;
            spi_cpha <= cfg_cpha;
            spi_lsb_first <= cfg_lsb_first;
            i2c_addr <= cfg_i2c_addr;
        end else if (if_mode == DAI_IF_I2C_SEL) begin
            // select pin picks the low address bit by hardware
            i2c_addr[0] <= select_or_alert_pin_in;
        end
    end
endmodule : dai_top

// File: dai_top_assertions.sv
`timescale 1ns/100ps
// watches alert, track pins, write lock and sticky flags
module dai_top_assertions
    import dai_pkg::*;
(
    input logic ref_clk,
    input logic sys_rst,
    input logic xfer_fail,
    input logic xfer_ok,
    input logic [dai_pkg::FLAG_N-1:0] irq_enable,
    input logic [1:0] hs_mode,
    input logic [3:0] track_drive,
    input logic lock_set,
    input logic write_req,
    input logic select_or_alert_pin_out,
    input logic select_or_alert_pin_oe,
    input logic [dai_pkg::FLAG_N-1:0] flags,
    input logic alert_active,
    input logic first_track_out_p,
    input logic first_track_out_n,
    input logic second_track_out_p,
    input logic second_track_out_n,
    input logic write_locked,
    input logic write_accept
);
    logic live; // high from the first edge after reset
    wire logic [3:0] pins = {second_track_out_n, second_track_out_p,
        first_track_out_n, first_track_out_p}; // track_drive order
    // keeps look-back checks away from the reset release edge
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            live <= 1'b0;
        end else begin
            live <= 1'b1;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    AST_ALERT_OR: assert property (live |-> alert_active ==
        |($past(flags) & $past(irq_enable))) else $error("alert mismatch");
    AST_OD_ZERO: assert property (!select_or_alert_pin_out)
        else $error("alert drives high");
    AST_OE_CAUSE: assert property (select_or_alert_pin_oe |->
        alert_active) else $error("alert without cause");
    AST_TRACK_LOW: assert property (live && alert_active &&
        $past(hs_mode) == 2'h1 |-> pins == 4'h0) else $error("not low");
    AST_TRACK_HIGH: assert property (live && alert_active &&
        $past(hs_mode) == 2'h2 |-> pins == 4'hF) else $error("not high");
    AST_TRACK_FOLLOW: assert property (live && (!alert_active ||
        $past(hs_mode) == 2'h0 || $past(hs_mode) == 2'h3) |->
        pins == $past(track_drive)) else $error("track wrong");
    AST_WRITE: assert property (live |-> write_accept ==
        ($past(write_req) && !$past(write_locked) && !$past(lock_set)))
        else $error("accept wrong");
    AST_LOCK: assert property ((lock_set || write_locked) |=>
        write_locked) else $error("lock lost");
    AST_SH_TWO: assert property (flags[F_SH_TWO] |=>
        flags[F_SH_TWO]) else $error("shadow flag dropped");
    AST_NV_TWO: assert property (flags[F_NV_TWO] |=>
        flags[F_NV_TWO]) else $error("memory flag dropped");
    AST_PROTO: assert property (xfer_fail |=> flags[F_PROTO])
        else $error("proto not set");
    AST_PROTO_CLR: assert property (xfer_ok && !xfer_fail |=>
        !flags[F_PROTO]) else $error("proto not cleared");
endmodule : dai_top_assertions

// File: diag_alarm_irq_unit_tb.sv
`timescale 1ns/100ps
// self-checking bench for the diagnostic alarm unit
module diag_alarm_irq_unit_tb;
    import dai_pkg::*;
    logic ref_clk, sys_rst, supply_5v_mode, data_access_err, internal_bus_err;
    logic internal_analog_supply_low, alert_pin_over, line_pin_over;
    logic incremental_mode, amplitude_low, shadow_valid, startup_active;
    logic nvm_valid, osc_tick, osc_run, lock_set, write_req, cfg_cpol;
    logic cfg_cpha, cfg_lsb_first, select_or_alert_pin_in, xfer_fail, xfer_ok;
    logic un_sel, select_or_alert_pin_out, select_or_alert_pin_oe;
    logic alert_active, first_track_out_p, first_track_out_n;
    logic second_track_out_p, second_track_out_n, write_locked, write_accept;
    logic spi_cpol, spi_cpha, spi_lsb_first;
    logic [1:0] over_trip, over_release, under_trip, under_release, trp, rls;
    logic [1:0] hs_mode, cfg_if_mode, if_mode;
    logic [12:0] shadow_word, nvm_word, irq_enable, flags;
    logic [15:0] osc_upper, osc_lower, osc_measure;
    logic [7:0] shadow_data, nvm_data;
    logic [3:0] track_drive;
    logic [6:0] cfg_i2c_addr, i2c_addr;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    wire logic [3:0] pins = {second_track_out_n, second_track_out_p,
        first_track_out_n, first_track_out_p};
    // rows: fault source, flag it should raise
    int rows[6][2] = '{'{0, F_ACCESS}, '{1, F_IBUS}, '{2, F_SUPPLY_PIN},
        '{3, F_SUPPLY_PIN}, '{4, F_SUPPLY_PIN}, '{5, F_LOW_AMP}};
    // one comparator pair serves over and under
    assign over_trip = un_sel ? 2'h0 : trp;
    assign under_trip = un_sel ? trp : 2'h0;
    assign over_release = un_sel ? 2'h0 : rls;
    assign under_release = un_sel ? rls : 2'h0;
    dai_top #(.GATE_CYC(20), .STUCK_CYC(8)) dut (.*);
    dai_host_model host (.ref_clk(ref_clk), .pin_oe(select_or_alert_pin_oe),
        .pin_level(select_or_alert_pin_in), .xfer_fail(xfer_fail),
        .xfer_ok(xfer_ok));
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // oscillator ticks every other cycle while running
    always @(negedge ref_clk) begin
        osc_tick <= osc_run & ~osc_tick & ~sys_rst;
    end
    // hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc
    task automatic chk(input string nm, input logic [15:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // even-parity hamming word: data at 3,5,6,7,9,10,11,12
    function automatic logic [12:0] enc(input logic [7:0] d);
        int pos[8] = '{3, 5, 6, 7, 9, 10, 11, 12};
        logic [12:0] w;
        w = 13'h0000;
        foreach (pos[i]) w[pos[i]] = d[i];
        for (int p = 1; p < 16; p = p * 2) begin
            for (int i = 1; i < 13; i++) begin
                if ((i & p) != 0 && i != p) w[p] ^= w[i];
            end
        end
        w[0] = ^w[12:1];
        return w;
    endfunction : enc
    task automatic set_src(input int s, input logic v);
        @(negedge ref_clk);
        case (s)
            0: data_access_err = v;
            1: internal_bus_err = v;
            2: internal_analog_supply_low = v;
            3: alert_pin_over = v;
            4: line_pin_over = v;
            default: amplitude_low = v;
        endcase
        cyc(2);
    endtask : set_src
    // other mode trips nothing; trip sets, holds after trip drops
    task automatic hyst(input logic un, input logic m);
        int b;
        b = un ? F_UNDER : F_OVER;
        @(negedge ref_clk);
        un_sel = un;
        supply_5v_mode = m;
        rls = 2'h0;
        trp = m ? 2'h1 : 2'h2;
        cyc(3);
        chk("wrong mode", flags[b], 1'b0);
        trp = m ? 2'h2 : 2'h1;
        cyc(3);
        chk("supply trip", flags[b], 1'b1);
        trp = 2'h0;
        cyc(3);
        chk("supply hold", flags[b], 1'b1);
        rls = 2'h3;
        cyc(3);
        chk("supply clear", flags[b], 1'b0);
    endtask : hyst
    task automatic word(input logic nv, input logic [12:0] cw);
        @(negedge ref_clk);
        nvm_word = cw;
        shadow_word = cw;
        nvm_valid = nv;
        shadow_valid = ~nv;
        @(negedge ref_clk);
        nvm_valid = 1'b0;
        shadow_valid = 1'b0;
        cyc(2);
    endtask : word
    task automatic wr(input logic exp);
        @(negedge ref_clk);
        write_req = 1'b1;
        @(negedge ref_clk);
        write_req = 1'b0;
        chk("write accept", write_accept, exp);
    endtask : wr
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        {sys_rst, startup_active, osc_run, cfg_cpol, cfg_lsb_first} = 5'h1F;
        {supply_5v_mode, data_access_err, internal_bus_err, un_sel} = 4'h0;
        {internal_analog_supply_low, alert_pin_over, line_pin_over} = 3'h0;
        {incremental_mode, amplitude_low, shadow_valid, nvm_valid} = 4'h0;
        {lock_set, write_req, cfg_cpha} = 3'h0;
        {trp, rls, hs_mode, irq_enable, track_drive} = 23'h00000F;
        {shadow_word, nvm_word, osc_lower} = 42'h0;
        osc_upper = 16'hFFFF;
        cfg_if_mode = 2'h2;
        cfg_i2c_addr = 7'h2A;
        cyc(4);
        chk("reset flags", flags, 16'h0000);
        chk("reset mode", if_mode, 2'h3);
        chk("reset addr", i2c_addr, 7'h00);
        sys_rst = 1'b0;
        $display("reset test done");
        word(1'b1, enc(8'h5A) ^ 13'h0020);
        chk("nvm fix", nvm_data, 8'h5A);
        chk("nvm one", flags[F_NV_ONE], 1'b1);
        word(1'b1, enc(8'h3C) ^ 13'h0300);
        chk("nvm two", flags[F_NV_TWO], 1'b1);
        word(1'b1, enc(8'h3C));
        chk("nvm one off", flags[F_NV_ONE], 1'b0);
        chk("mode early", if_mode, 2'h3);
        chk("sel bit", i2c_addr, 7'h01);
        startup_active = 1'b0;
        cyc(3);
        chk("mode", if_mode, 2'h2);
        chk("spi cfg", {spi_cpol, spi_cpha, spi_lsb_first}, 3'h5);
        chk("i2c addr", i2c_addr, 7'h2A);
        {cfg_cpha, cfg_if_mode} = 3'h4;
        word(1'b1, enc(8'hFF) ^ 13'h0002);
        chk("no recapture", {if_mode, spi_cpha}, 3'h4);
        chk("nvm after start", flags[F_NV_ONE], 1'b0);
        chk("nvm data kept", nvm_data, 8'h3C);
        $display("start-up test done");
        incremental_mode = 1'b1;
        foreach (rows[i]) begin
            set_src(rows[i][0], 1'b1);
            chk("flag on", flags[rows[i][1]], 1'b1);
            set_src(rows[i][0], 1'b0);
            chk("flag off", flags[rows[i][1]], 1'b0);
        end
        incremental_mode = 1'b0;
        set_src(5, 1'b1);
        chk("amp outside mode", flags[F_LOW_AMP], 1'b0);
        set_src(5, 1'b0);
        for (int k = 0; k < 4; k++) begin
            hyst(k[1], k[0]);
        end
        $display("flag table test done");
        word(1'b0, enc(8'hA5) ^ 13'h1000);
        chk("shadow fix", shadow_data, 8'hA5);
        chk("shadow one", flags[F_SH_ONE], 1'b1);
        word(1'b0, enc(8'h0F) ^ 13'h0041);
        chk("shadow two", flags[F_SH_TWO], 1'b1);
        word(1'b0, enc(8'h0F));
        chk("shadow one off", flags[F_SH_ONE], 1'b0);
        chk("shadow two kept", flags[F_SH_TWO], 1'b1);
        $display("memory check test done");
        cyc(45);
        chk("osc count", osc_measure, 16'h000A);
        chk("osc in range", flags[F_OSC_RANGE], 1'b0);
        osc_lower = 16'h000B;
        cyc(45);
        chk("osc below", flags[F_OSC_RANGE], 1'b1);
        {osc_lower, osc_upper} = 32'h000A000A;
        cyc(45);
        chk("osc at limits", flags[F_OSC_RANGE], 1'b0);
        osc_run = 1'b0;
        cyc(12);
        chk("osc stuck", flags[F_OSC_STUCK], 1'b1);
        osc_run = 1'b1;
        cyc(4);
        chk("osc running", flags[F_OSC_STUCK], 1'b0);
        $display("oscillator test done");
        {irq_enable, hs_mode, track_drive} = 19'h0011A;
        set_src(0, 1'b1);
        cyc(1);
        chk("alert", {alert_active, select_or_alert_pin_in}, 2'h2);
        chk("track low", pins, 4'h0);
        hs_mode = 2'h2;
        cyc(2);
        chk("track high", pins, 4'hF);
        set_src(0, 1'b0);
        set_src(1, 1'b1);
        cyc(1);
        chk("alert off", {alert_active, select_or_alert_pin_in}, 2'h1);
        chk("track normal", pins, 4'hA);
        set_src(1, 1'b0);
        host.transfer(1'b1);
        chk("proto fail", flags[F_PROTO], 1'b1);
        host.transfer(1'b0);
        chk("proto ok", flags[F_PROTO], 1'b0);
        $display("alert test done");
        wr(1'b1);
        lock_set = 1'b1;
        cyc(1);
        lock_set = 1'b0;
        wr(1'b0);
        chk("locked", write_locked, 1'b1);
        sys_rst = 1'b1;
        cyc(2);
        sys_rst = 1'b0;
        cyc(2);
        chk("por clears", {flags[F_SH_TWO], write_locked}, 2'h0);
        $display("lock test done");
        report_and_stop();
    end
endmodule : diag_alarm_irq_unit_tb
bind dai_top dai_top_assertions u_chk (.*);
